// File: hw/sleep_wake_pkg.sv
// Register map, field layout and state encoding of the wake-up controller.
// Assumes a 32-bit register port with byte offsets and one system clock.
package sleep_wake_pkg;

	// Register byte offsets
	localparam logic [11:0] DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS = 12'h108;
	localparam logic [11:0] DEEP_SLEEP_TIMER_COUNTS_OFS       = 12'h10c;
	localparam logic [11:0] SLEEP_WAKE_SOURCE_ENABLE_OFS      = 12'h110;
	localparam logic [11:0] SLEEP_TIMER_COUNT_OFS             = 12'h114;
	localparam logic [11:0] PEER_WAKE_REQUEST_OFS             = 12'h118;
	localparam logic [11:0] WAKE_CAUSE_STATUS_OFS             = 12'h120;
	localparam logic [11:0] WAKE_CAUSE_MASK_OFS               = 12'h124;
	localparam int          ADDR_W                            = 12;
	localparam int          DATA_W                            = 32;

	// Wake source enable fields, same for sleep and deep sleep
	localparam int TIMER_WAKE_EN_BIT = 0;
	localparam int PEER_WAKE_EN_BIT  = 1;
	localparam int ENABLE_W          = 2;

	// Deep-sleep timer count fields
	localparam int DS_WAKE_POINT_LSB = 0;
	localparam int DS_OPP_POINT_LSB  = 16;
	localparam int DS_FIELD_W        = 16;

	// Peer wake request field
	localparam int PEER_WAKE_REQ_BIT = 0;

	// Wake cause status and mask fields
	localparam int SLEEP_PEER_CAUSE_BIT = 0;
	localparam int DEEP_PEER_CAUSE_BIT  = 1;
	localparam int SLEEP_TIMER_CAUSE_BIT = 2;
	localparam int DEEP_TIMER_CAUSE_BIT = 3;
	localparam int PLL_LOCKED_BIT       = 12;
	localparam int RTC_ALARM_BIT        = 14;
	localparam int CAUSE_W              = 15;
	localparam logic [CAUSE_W-1:0] CAUSE_IMPLEMENTED = 15'h500f;

	// Reset values
	localparam logic [DATA_W-1:0]   REG_RESET    = 32'h0000_0000;
	localparam logic [ENABLE_W-1:0] ENABLE_RESET = 2'h0;
	localparam logic [CAUSE_W-1:0]  CAUSE_RESET  = 15'h0000;
	localparam logic [DATA_W-1:0]   READ_ZERO    = 32'h0000_0000;

	// Power state, Gray coded along run, sleep, deep sleep
	typedef enum logic [1:0] {
		ST_RUN        = 2'h0,
		ST_SLEEP      = 2'h1,
		ST_DEEP_SLEEP = 2'h3
	} power_state_t;

endpackage : sleep_wake_pkg

// File: hw/app_sleep_wake_control.sv
// Sleep and deep-sleep wake-up controller of the application subsystem.
// Assumes sleep and deep-sleep entry strobes come from logic on clock_i;
// peer wake, peer low-power, slow clock, alarm and lock come from pins.
`timescale 1ns/1ps

// What this block does
// - Deep-sleep peer wake enable lets a peer request end deep sleep, else ignored.
// - Deep-sleep timer wake enable runs the deep-sleep timer so it may end deep sleep.
// - Upper deep-sleep field, in slow clocks, sets when the operating point request rises.
// - Lower deep-sleep field, in slow clocks, sets when the wake request rises.
// - Sleep peer wake enable lets a peer request end sleep, else not.
// - Sleep timer wake enable lets sleep timer expiry end sleep, else not.
// - Sleep wake duration is a full 32-bit count of system clocks.
// - Writing one to the request bit asks the low-power peer to wake.
// - All enables, counts and the request bit reset to zero.
// - Status bits 3..0 report deep timer, sleep timer, deep peer, sleep peer wake.
// - Status bit 14 on alarm, bit 12 on lock, each raising the interrupt.
module app_sleep_wake_control
	import sleep_wake_pkg::*;
#(
	parameter int SLEEP_COUNT_W = 32,
	parameter int DEEP_COUNT_W  = DS_FIELD_W
) (
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rd_data_o,
	input  wire logic              sleep_enter_i,
	input  wire logic              deep_sleep_enter_i,
	input  wire logic              peer_wake_i,
	input  wire logic              peer_low_power_i,
	input  wire logic              slow_clk_i,
	input  wire logic              rtc_alarm_i,
	input  wire logic              pll_lock_i,
	output logic                   wake_o,
	output logic                   opp_request_o,
	output logic                   peer_wake_request_o,
	output logic      [1:0]        power_state_o,
	output logic                   irq_o
);

	// Software-visible registers
	logic [ENABLE_W-1:0]      deep_sleep_wake_source_enable;
	logic [DATA_W-1:0]        deep_sleep_timer_counts;
	logic [ENABLE_W-1:0]      sleep_wake_source_enable;
	logic [SLEEP_COUNT_W-1:0] sleep_timer_count;
	logic                     peer_wake_request_bit;
	logic [CAUSE_W-1:0]       wake_cause_status;
	logic [CAUSE_W-1:0]       wake_cause_mask;

	// Named fields of the enables and counts
	logic                    deep_sleep_timer_wake_enable;
	logic                    deep_sleep_peer_wake_enable;
	logic                    sleep_timer_wake_enable;
	logic                    sleep_peer_wake_enable;
	logic [DEEP_COUNT_W-1:0] deep_sleep_opp_point_count;
	logic [DEEP_COUNT_W-1:0] deep_sleep_wake_point_count;

	// Synchronisers for pin inputs
	logic [1:0] peer_wake_sync;
	logic [1:0] peer_lp_sync;
	logic [1:0] slow_clk_sync;
	logic [1:0] rtc_alarm_sync;
	logic [1:0] pll_lock_sync;
	logic       slow_clk_prev;
	logic       rtc_alarm_prev;
	logic       pll_lock_prev;
	logic       slow_tick;
	logic       rtc_alarm_rise;
	logic       pll_lock_rise;
	logic       peer_wake;

	// Power state and timers
	power_state_t             state;
	power_state_t             next_state;
	logic [SLEEP_COUNT_W-1:0] sleep_elapsed;
	logic [DEEP_COUNT_W-1:0]  deep_elapsed;
	logic                     sleep_timer_hit;
	logic                     sleep_peer_hit;
	logic                     deep_timer_hit;
	logic                     deep_peer_hit;
	logic                     deep_opp_hit;
	logic                     any_wake;

	// Register port decode
	logic                     wr_enable_deep;
	logic                     wr_counts_deep;
	logic                     wr_enable_sleep;
	logic                     wr_count_sleep;
	logic                     wr_peer_req;
	logic                     wr_status;
	logic                     wr_mask;
	logic [CAUSE_W-1:0]       cause_set;
	logic [CAUSE_W-1:0]       cause_clear;
	logic [DATA_W-1:0]        next_rd_data;

	assign deep_sleep_timer_wake_enable = deep_sleep_wake_source_enable[TIMER_WAKE_EN_BIT];
	assign deep_sleep_peer_wake_enable  = deep_sleep_wake_source_enable[PEER_WAKE_EN_BIT];
	assign sleep_timer_wake_enable      = sleep_wake_source_enable[TIMER_WAKE_EN_BIT];
	assign sleep_peer_wake_enable       = sleep_wake_source_enable[PEER_WAKE_EN_BIT];
	assign deep_sleep_opp_point_count   =
		deep_sleep_timer_counts[DS_OPP_POINT_LSB +: DEEP_COUNT_W];
	assign deep_sleep_wake_point_count  =
		deep_sleep_timer_counts[DS_WAKE_POINT_LSB +: DEEP_COUNT_W];

	// Write strobes per register
	assign wr_enable_deep  = wr_i && (addr_i == DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS);
	assign wr_counts_deep  = wr_i && (addr_i == DEEP_SLEEP_TIMER_COUNTS_OFS);
	assign wr_enable_sleep = wr_i && (addr_i == SLEEP_WAKE_SOURCE_ENABLE_OFS);
	assign wr_count_sleep  = wr_i && (addr_i == SLEEP_TIMER_COUNT_OFS);
	assign wr_peer_req     = wr_i && (addr_i == PEER_WAKE_REQUEST_OFS);
	assign wr_status       = wr_i && (addr_i == WAKE_CAUSE_STATUS_OFS);
	assign wr_mask         = wr_i && (addr_i == WAKE_CAUSE_MASK_OFS);

	// Two-stage synchronisers and edge history; only the second stage is read onward
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peer_wake_sync <= 2'h0;
			peer_lp_sync   <= 2'h0;
			slow_clk_sync  <= 2'h0;
			rtc_alarm_sync <= 2'h0;
			pll_lock_sync  <= 2'h0;
			slow_clk_prev  <= 1'b0;
			rtc_alarm_prev <= 1'b0;
			pll_lock_prev  <= 1'b0;
		end else if (ce_i) begin
			peer_wake_sync <= {peer_wake_sync[0], peer_wake_i};
			peer_lp_sync   <= {peer_lp_sync[0], peer_low_power_i};
			slow_clk_sync  <= {slow_clk_sync[0], slow_clk_i};
			rtc_alarm_sync <= {rtc_alarm_sync[0], rtc_alarm_i};
			pll_lock_sync  <= {pll_lock_sync[0], pll_lock_i};
			slow_clk_prev  <= slow_clk_sync[1];
			rtc_alarm_prev <= rtc_alarm_sync[1];
			pll_lock_prev  <= pll_lock_sync[1];
		end
	end

	// Slow clock must be well below clock_i or ticks are missed
	assign slow_tick      = slow_clk_sync[1] && !slow_clk_prev;
	assign rtc_alarm_rise = rtc_alarm_sync[1] && !rtc_alarm_prev;
	assign pll_lock_rise  = pll_lock_sync[1] && !pll_lock_prev;
	assign peer_wake      = peer_wake_sync[1];

	// Wake conditions, each gated by its own enable
	assign sleep_timer_hit = (state == ST_SLEEP) && sleep_timer_wake_enable &&
		(sleep_elapsed == sleep_timer_count);
	assign sleep_peer_hit  = (state == ST_SLEEP) && sleep_peer_wake_enable &&
		peer_wake;
	assign deep_timer_hit  = (state == ST_DEEP_SLEEP) && deep_sleep_timer_wake_enable &&
		slow_tick && (deep_elapsed == deep_sleep_wake_point_count);
	assign deep_opp_hit    = (state == ST_DEEP_SLEEP) && deep_sleep_timer_wake_enable &&
		slow_tick && (deep_elapsed == deep_sleep_opp_point_count);
	assign deep_peer_hit   = (state == ST_DEEP_SLEEP) && deep_sleep_peer_wake_enable &&
		peer_wake;
	assign any_wake = sleep_timer_hit || sleep_peer_hit || deep_timer_hit || deep_peer_hit;

	// Next power state; a wake always returns to run
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN: begin
				if (deep_sleep_enter_i) begin
					next_state = ST_DEEP_SLEEP;
				end else if (sleep_enter_i) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (sleep_timer_hit || sleep_peer_hit) begin
					next_state = ST_RUN;
				end
			end
			ST_DEEP_SLEEP: begin
				if (deep_timer_hit || deep_peer_hit) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// Power state and its registered copy for the outside
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state         <= ST_RUN;
			power_state_o <= ST_RUN;
		end else if (ce_i) begin
			state         <= next_state;
			power_state_o <= next_state;
		end
	end

	// Sleep timer: clears on entry, counts system clocks while asleep
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_elapsed <= '0;
		end else if (ce_i) begin
			if (state != ST_SLEEP) begin
				sleep_elapsed <= '0;
			end else if (!sleep_timer_hit) begin
				sleep_elapsed <= sleep_elapsed + 1'b1;
			end
		end
	end

	// Deep-sleep timer: runs only when enabled, one step per slow tick
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			deep_elapsed <= '0;
		end else if (ce_i) begin
			if (state != ST_DEEP_SLEEP) begin
				deep_elapsed <= '0;
			end else if (deep_sleep_timer_wake_enable && slow_tick) begin
				deep_elapsed <= deep_elapsed + 1'b1;
			end
		end
	end

	// Operating point request rises at its point, falls on leaving deep sleep
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			opp_request_o <= 1'b0;
		end else if (ce_i) begin
			if (state != ST_DEEP_SLEEP || next_state != ST_DEEP_SLEEP) begin
				opp_request_o <= 1'b0;
			end else if (deep_opp_hit) begin
				opp_request_o <= 1'b1;
			end
		end
	end

	// Wake pulse: one cycle per exit from sleep or deep sleep
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_o <= 1'b0;
		end else if (ce_i) begin
			wake_o <= any_wake;
		end
	end

	// Enables and counts, all zero so no source wakes after reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			deep_sleep_wake_source_enable <= ENABLE_RESET;
			deep_sleep_timer_counts       <= REG_RESET;
			sleep_wake_source_enable      <= ENABLE_RESET;
			sleep_timer_count             <= '0;
		end else if (ce_i) begin
			if (wr_enable_deep) begin
				deep_sleep_wake_source_enable <= wr_data_i[ENABLE_W-1:0];
			end
			if (wr_counts_deep) begin
				deep_sleep_timer_counts <= wr_data_i;
			end
			if (wr_enable_sleep) begin
				sleep_wake_source_enable <= wr_data_i[ENABLE_W-1:0];
			end
			if (wr_count_sleep) begin
				sleep_timer_count <= wr_data_i[SLEEP_COUNT_W-1:0];
			end
		end
	end

	// Request bit held until software writes zero; reaches the peer only while it naps
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peer_wake_request_bit <= 1'b0;
			peer_wake_request_o   <= 1'b0;
		end else if (ce_i) begin
			if (wr_peer_req) begin
				peer_wake_request_bit <= wr_data_i[PEER_WAKE_REQ_BIT];
			end
			peer_wake_request_o <= peer_wake_request_bit && peer_lp_sync[1];
		end
	end

	// Cause events and write-one-to-clear mask
	always_comb begin
		cause_set = CAUSE_RESET;
		cause_set[SLEEP_PEER_CAUSE_BIT]  = sleep_peer_hit;
		cause_set[DEEP_PEER_CAUSE_BIT]   = deep_peer_hit;
		cause_set[SLEEP_TIMER_CAUSE_BIT] = sleep_timer_hit;
		cause_set[DEEP_TIMER_CAUSE_BIT]  = deep_timer_hit;
		cause_set[PLL_LOCKED_BIT]        = pll_lock_rise;
		cause_set[RTC_ALARM_BIT]         = rtc_alarm_rise;
		cause_clear = wr_status ? wr_data_i[CAUSE_W-1:0] : CAUSE_RESET;
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_cause_status <= CAUSE_RESET;
		end else if (ce_i) begin
			wake_cause_status <= (wake_cause_status & ~cause_clear) | cause_set;
		end
	end

	// Interrupt mask; unimplemented bits never stick
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_cause_mask <= CAUSE_RESET;
		end else if (ce_i && wr_mask) begin
			wake_cause_mask <= wr_data_i[CAUSE_W-1:0] & CAUSE_IMPLEMENTED;
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(wake_cause_status & wake_cause_mask);
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rd_data = READ_ZERO;
		unique case (addr_i)
			DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS: begin
				next_rd_data[ENABLE_W-1:0] = deep_sleep_wake_source_enable;
			end
			DEEP_SLEEP_TIMER_COUNTS_OFS: begin
				next_rd_data = deep_sleep_timer_counts;
			end
			SLEEP_WAKE_SOURCE_ENABLE_OFS: begin
				next_rd_data[ENABLE_W-1:0] = sleep_wake_source_enable;
			end
			SLEEP_TIMER_COUNT_OFS: begin
				next_rd_data[SLEEP_COUNT_W-1:0] = sleep_timer_count;
			end
			PEER_WAKE_REQUEST_OFS: begin
				next_rd_data[PEER_WAKE_REQ_BIT] = peer_wake_request_bit;
			end
			WAKE_CAUSE_STATUS_OFS: begin
				next_rd_data[CAUSE_W-1:0] = wake_cause_status;
			end
			WAKE_CAUSE_MASK_OFS: begin
				next_rd_data[CAUSE_W-1:0] = wake_cause_mask;
			end
			default: begin
				next_rd_data = READ_ZERO;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= READ_ZERO;
		end else if (ce_i) begin
			rd_data_o <= rd_i ? next_rd_data : READ_ZERO;
		end
	end

endmodule : app_sleep_wake_control

// File: verification/sleep_wake_assertions.sv
// Port checker of the wake-up controller.
// Assumes binding to app_sleep_wake_control; shadows only enable, mask and request writes.
`timescale 1ns/1ps
module sleep_wake_checker
	import sleep_wake_pkg::*;
#(
	parameter int SLEEP_COUNT_W = 32,
	parameter int DEEP_COUNT_W  = 16
) (
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic              ce_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [DATA_W-1:0] rd_data_o,
	input wire logic              sleep_enter_i,
	input wire logic              deep_sleep_enter_i,
	input wire logic              peer_low_power_i,
	input wire logic              wake_o,
	input wire logic              opp_request_o,
	input wire logic              peer_wake_request_o,
	input wire logic [1:0]        power_state_o,
	input wire logic              irq_o
);
	logic [1:0]  sen, den;
	logic [14:0] msk;
	logic        preq;
	// Shadows updated on the same edge as the registers they mirror
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sen  <= 2'h0;
			den  <= 2'h0;
			msk  <= 15'h0000;
			preq <= 1'b0;
		end else if (ce_i && wr_i) begin
			if (addr_i == SLEEP_WAKE_SOURCE_ENABLE_OFS) sen <= wr_data_i[1:0];
			if (addr_i == DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS) den <= wr_data_i[1:0];
			if (addr_i == WAKE_CAUSE_MASK_OFS) msk <= wr_data_i[14:0] & CAUSE_IMPLEMENTED;
			if (addr_i == PEER_WAKE_REQUEST_OFS) preq <= wr_data_i[0];
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Request must reach the peer through two sync stages and one register
	sequence s_req_held;
		(preq && peer_low_power_i) [*4];
	endsequence
	property p_req_on;
		s_req_held |=> peer_wake_request_o;
	endproperty
	chk_req_reaches_peer: assert property (p_req_on)
		else $error("wake request not passed to sleeping peer");
	chk_req_stays_off: assert property (!preq |=> !peer_wake_request_o)
		else $error("wake request raised without request bit");
	chk_sleep_no_source: assert property (
		power_state_o == ST_SLEEP && sen == 2'h0 |=> !wake_o)
		else $error("sleep ended with all sources disabled");
	chk_deep_no_source: assert property (
		power_state_o == ST_DEEP_SLEEP && den == 2'h0 |=> !wake_o)
		else $error("deep sleep ended with all sources disabled");
	chk_wake_single_run: assert property (
		wake_o |-> power_state_o == ST_RUN && $past(power_state_o) != ST_RUN ##1 !wake_o)
		else $error("wake pulse malformed");
	chk_sleep_entry: assert property (
		ce_i && power_state_o == ST_RUN && sleep_enter_i && !deep_sleep_enter_i
		|=> power_state_o == ST_SLEEP) else $error("sleep entry missed");
	chk_deep_entry: assert property (
		ce_i && power_state_o == ST_RUN && deep_sleep_enter_i
		|=> power_state_o == ST_DEEP_SLEEP) else $error("deep sleep entry missed");
	chk_point_clears: assert property (
		power_state_o == ST_RUN && $past(power_state_o) == ST_RUN
		&& $past(power_state_o, 2) == ST_RUN |-> !opp_request_o)
		else $error("operating point request outside deep sleep");
	chk_irq_masked: assert property (msk == 15'h0000 |=> !irq_o)
		else $error("interrupt with every mask bit clear");
	chk_status_reserved: assert property (
		ce_i && rd_i && addr_i == WAKE_CAUSE_STATUS_OFS |=>
		(rd_data_o & ~32'h0000_500f) == 32'h0000_0000)
		else $error("status reserved bits not zero");
endmodule : sleep_wake_checker

bind app_sleep_wake_control sleep_wake_checker #(
	.SLEEP_COUNT_W(SLEEP_COUNT_W), .DEEP_COUNT_W(DEEP_COUNT_W)
) i_sleep_wake_checker (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
	.sleep_enter_i(sleep_enter_i), .deep_sleep_enter_i(deep_sleep_enter_i),
	.peer_low_power_i(peer_low_power_i), .wake_o(wake_o), .opp_request_o(opp_request_o),
	.peer_wake_request_o(peer_wake_request_o), .power_state_o(power_state_o), .irq_o(irq_o)
);

// File: verification/peer_power_model.sv
// Behavioural model of the peer power manager.
// Assumes the bench steers naps, wake asks and the wake-up latency.
`timescale 1ns/1ps
module peer_power_model (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       nap_i,
	input  wire logic       ask_wake_i,
	input  wire logic [3:0] lat_i,
	input  wire logic       wake_req_i,
	output logic            peer_wake_o,
	output logic            low_power_o
);
	logic [3:0] cnt;
	// Peer asks for an application wake by a held level
	assign peer_wake_o = ask_wake_i;
	// Napping peer wakes lat_i cycles after seeing the request
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_power_o <= 1'b0;
			cnt         <= 4'h0;
		end else if (nap_i) begin
			low_power_o <= 1'b1;
			cnt         <= 4'h0;
		end else if (low_power_o && wake_req_i) begin
			cnt <= cnt + 4'h1;
			if (cnt == lat_i) low_power_o <= 1'b0;
		end
	end
endmodule : peer_power_model

// File: verification/app_sleep_wake_control_test.sv
// Self-checking bench of the wake-up controller with the peer model.
// Assumes a 20 MHz clock_i; the slow clock runs here at one eighth of it.
`timescale 1ns/1ps
module app_sleep_wake_control_test;
	import sleep_wake_pkg::*;
	logic              clock_i, rst_n_i, ce_i, wr_i, rd_i, rd_pend, wake_o, irq_o;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wr_data_i, rd_data_o, v;
	logic              sleep_enter_i, deep_sleep_enter_i, peer_wake_i, peer_low_power_i;
	logic              slow_clk_i, rtc_alarm_i, pll_lock_i, nap, ask, opp_request_o;
	logic              peer_wake_request_o;
	logic [1:0]        power_state_o, sdiv;
	logic [3:0]        lat;
	logic [DATA_W-1:0] exp_q[$];
	int                n_errors, check_count, k, ko, n;
	logic [ADDR_W-1:0] ofs[7] = '{DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, DEEP_SLEEP_TIMER_COUNTS_OFS,
		SLEEP_WAKE_SOURCE_ENABLE_OFS, SLEEP_TIMER_COUNT_OFS, PEER_WAKE_REQUEST_OFS,
		WAKE_CAUSE_STATUS_OFS, WAKE_CAUSE_MASK_OFS};

	app_sleep_wake_control i_app_sleep_wake_control (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.sleep_enter_i(sleep_enter_i), .deep_sleep_enter_i(deep_sleep_enter_i),
		.peer_wake_i(peer_wake_i), .peer_low_power_i(peer_low_power_i),
		.slow_clk_i(slow_clk_i), .rtc_alarm_i(rtc_alarm_i), .pll_lock_i(pll_lock_i),
		.wake_o(wake_o), .opp_request_o(opp_request_o), .peer_wake_request_o(peer_wake_request_o),
		.power_state_o(power_state_o), .irq_o(irq_o));
	peer_power_model i_peer_power_model (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .nap_i(nap), .ask_wake_i(ask), .lat_i(lat),
		.wake_req_i(peer_wake_request_o), .peer_wake_o(peer_wake_i),
		.low_power_o(peer_low_power_i));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// Slow clock free running, period of eight system clocks
	always @(posedge clock_i) begin
		sdiv <= sdiv + 2'h1;
		if (sdiv == 2'h3) slow_clk_i <= ~slow_clk_i;
	end
	// Read data stand only in the cycle after the strobe
	always @(posedge clock_i) rd_pend <= rd_i;
	always @(negedge clock_i) if (rd_pend === 1'b1) check("rd_data_o", rd_data_o, exp_q.pop_front());

	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask : rd
	task automatic enter(input logic deep);
		@(posedge clock_i);
		sleep_enter_i      <= ~deep;
		deep_sleep_enter_i <= deep;
		@(posedge clock_i);
		sleep_enter_i      <= 1'b0;
		deep_sleep_enter_i <= 1'b0;
	endtask : enter
	function automatic logic sig(input int w);
		case (w)
			0: return wake_o;
			1: return peer_wake_request_o;
			default: return peer_low_power_i;
		endcase
	endfunction : sig
	// Bounded wait; also notes when the operating point request first shows
	task automatic wait_for(input int w, input logic lvl, input int m);
		k = 0;
		while (sig(w) !== lvl && k < m) begin
			@(posedge clock_i);
			#1;
			k++;
			if (opp_request_o === 1'b1 && ko == 0) ko = k;
		end
	endtask : wait_for
	task automatic cause(input logic [DATA_W-1:0] e);
		rd(WAKE_CAUSE_STATUS_OFS, e);
		wr(WAKE_CAUSE_STATUS_OFS, e);
	endtask : cause
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge clock_i);
		n_errors++;
		test_done();
	end

	initial begin
		{rst_n_i, wr_i, rd_i, rd_pend, sleep_enter_i, deep_sleep_enter_i, nap, ask} = '0;
		{rtc_alarm_i, pll_lock_i, slow_clk_i} = '0;
		{ce_i, addr_i, wr_data_i, lat, sdiv, n_errors, check_count, ko} = '0;
		ce_i = 1'b1;
		v    = $urandom(61);
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		// Reset values, unmapped space, readback and reserved bits
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		rd(12'h11c, 32'h0);
		v = $urandom;
		wr(DEEP_SLEEP_TIMER_COUNTS_OFS, v);
		rd(DEEP_SLEEP_TIMER_COUNTS_OFS, v);
		wr(SLEEP_TIMER_COUNT_OFS, ~v);
		rd(SLEEP_TIMER_COUNT_OFS, ~v);
		wr(SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'hffff_ffff);
		rd(SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h3);
		wr(DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'hffff_fffe);
		rd(DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h2);
		// Sleep with no source stays asleep; peer enable then ends it
		wr(SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h0);
		wr(SLEEP_TIMER_COUNT_OFS, 32'h3);
		enter(1'b0);
		ask <= 1'b1;
		wait_for(0, 1'b1, 30);
		check("sleep_hold", k, 30);
		check("state", power_state_o, ST_SLEEP);
		wr(SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h2);
		wait_for(0, 1'b1, 10);
		check("peer_wake", wake_o, 1'b1);
		ask <= 1'b0;
		cause(32'h1);
		// Sleep timer at a random count, exact latency, interrupt
		n = $urandom % 16;
		wr(SLEEP_TIMER_COUNT_OFS, n);
		wr(SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h1);
		wr(WAKE_CAUSE_MASK_OFS, 32'h4);
		enter(1'b0);
		wait_for(0, 1'b1, 40);
		check("timer_wake", k, n + 1);
		@(posedge clock_i);
		#1 check("irq_o", irq_o, 1'b1);
		cause(32'h4);
		// Deep sleep ignores the peer until enabled
		wr(DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h0);
		enter(1'b1);
		ask <= 1'b1;
		wait_for(0, 1'b1, 30);
		check("deep_hold", k, 30);
		check("deep_state", power_state_o, ST_DEEP_SLEEP);
		wr(DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h2);
		wait_for(0, 1'b1, 10);
		check("deep_peer", wake_o, 1'b1);
		ask <= 1'b0;
		cause(32'h2);
		// Deep timer: point at tick 2, wake at tick 4, eight clocks a tick
		wr(DEEP_SLEEP_TIMER_COUNTS_OFS, 32'h0001_0003);
		wr(DEEP_SLEEP_WAKE_SOURCE_ENABLE_OFS, 32'h1);
		ko = 0;
		enter(1'b1);
		wait_for(0, 1'b1, 80);
		check("point_gap", k - ko, 16);
		check("deep_timer", wake_o, 1'b1);
		repeat (3) @(posedge clock_i);
		#1 check("point_clear", opp_request_o, 1'b0);
		cause(32'h8);
		// Request reaches a napping peer, which wakes after its latency
		// Latency of two or more keeps the request standing long enough to be checked
		lat <= 4'h2 + 4'($urandom % 6);
		nap <= 1'b1;
		@(posedge clock_i);
		nap <= 1'b0;
		wr(PEER_WAKE_REQUEST_OFS, 32'hffff_ffff);
		wait_for(1, 1'b1, 10);
		check("req_up", peer_wake_request_o, 1'b1);
		wait_for(2, 1'b0, 20);
		wait_for(1, 1'b0, 5);
		check("req_down", peer_wake_request_o, 1'b0);
		rd(PEER_WAKE_REQUEST_OFS, 32'h1);
		wr(PEER_WAKE_REQUEST_OFS, 32'h0);
		// Alarm and lock events, mask layout, write-one-to-clear
		wr(WAKE_CAUSE_MASK_OFS, 32'hffff_ffff);
		rd(WAKE_CAUSE_MASK_OFS, 32'h0000_500f);
		wr(WAKE_CAUSE_MASK_OFS, 32'h0000_4000);
		rtc_alarm_i <= 1'b1;
		pll_lock_i  <= 1'b1;
		repeat (6) @(posedge clock_i);
		#1 check("irq_o", irq_o, 1'b1);
		rd(WAKE_CAUSE_STATUS_OFS, 32'h0000_5000);
		wr(WAKE_CAUSE_STATUS_OFS, 32'h0000_4000);
		rd(WAKE_CAUSE_STATUS_OFS, 32'h0000_1000);
		#1 check("irq_o", irq_o, 1'b0);
		repeat (3) @(posedge clock_i);
		test_done();
	end
endmodule : app_sleep_wake_control_test
